/* File: rtl/gpc_chg_det.sv */
// gpc_chg_det: per-pin edge detectors and sticky change flags.
// assumes level arrives already synchronised and gated; ce freezes all state.
`timescale 1ns/10ps
module gpc_chg_det
   import gpc_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   gpc_chg_if.det_side io
);

   logic [W-1:0] prev_q;
   logic [W-1:0] flag_q;
   logic [1:0] prime_q;
   logic primed;
   logic [W-1:0] rise;
   logic [W-1:0] fall;

   assign primed = (prime_q == GPC_PRIME_CYCLES);

   // [R16] compare consecutive samples
   assign rise = io.level & ~prev_q;
   assign fall = ~io.level & prev_q;

   // [R6] [R8] [R9] [R10] per-pin edge selection
   assign io.det = primed ? ((rise & io.rise_en) | (fall & io.fall_en)) : '0;
   assign io.flag = flag_q;

   // history sample of the synchronised level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_q <= '0;
      end else if (ce) begin
         prev_q <= io.level;
      end
   end

   // hold off detection until the sync chain and history are filled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prime_q <= 2'h0;
      end else if (ce && !primed) begin
         prime_q <= prime_q + 2'h1;
      end
   end

   // [R11] [R13] sticky flags, a new edge wins over a clearing write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_q <= GPC_RST_FLAG[W-1:0];
      end else if (ce) begin
         if (io.flag_wr) begin
            flag_q <= io.flag_wdata | io.det;
         end else begin
            flag_q <= flag_q | io.det;
         end
      end
   end

endmodule

/* File: rtl/gpc_chg_if.sv */
// gpc_chg_if: signals between the port block and its change detector.
// assumes both ends run on the same clock.
`timescale 1ns/10ps
interface gpc_chg_if #(
   parameter int W = 8
);
   logic [W-1:0] level;
   logic [W-1:0] rise_en;
   logic [W-1:0] fall_en;
   logic flag_wr;
   logic [W-1:0] flag_wdata;
   logic [W-1:0] flag;
   logic [W-1:0] det;

   modport ctrl (
      output level,
      output rise_en,
      output fall_en,
      output flag_wr,
      output flag_wdata,
      input flag,
      input det
   );

   modport det_side (
      input level,
      input rise_en,
      input fall_en,
      input flag_wr,
      input flag_wdata,
      output flag,
      output det
   );
endinterface

/* File: rtl/gpc_pkg.sv */
// gpc_pkg: constants for the general purpose port block with change interrupt.
// assumes a byte-wide register port addressed by an 8-bit index, one clock domain.
//
// Overview of operation
// [R1] a pin owned by a peripheral never takes the gpio driver, yet reads back
// [R2] up to five ports, each with direction, level and output latch registers
// [R3] a write to the latch register acts exactly like a write to the level register
// [R4] latch register reads stored latch; level register reads sampled pin levels
// [R5] analog select bit blocks the pin's digital input path
// [R6] each second_port pin may raise a change event on rising or falling edges
// [R7] with master enable clear, edges still set flags but raise no interrupt
// [R8] rising enable bit set turns on rising-edge detection for that pin
// [R9] falling enable bit set turns on falling-edge detection for that pin
// [R10] both enable bits set detect and flag both directions
// [R11] an enabled edge sets the pin flag and interrupts when master enabled; irq here also needs the mask bit set
// [R12] combined change flag is the continuous or of all pin flags
// [R13] writing zero clears a flag, but a coinciding edge leaves it set
// [R14] with master enable set an edge wakes the device, flags already updated
// [R15] direction one makes an input with driver off; zero drives the latch
// [R16] pins are synchronised first; edges compare consecutive synchronised samples
package gpc_pkg;

   // register port widths
   localparam int GPC_ADDR_W = 8;
   localparam int GPC_DATA_W = 8;

   // per-port register slots: address = port index * 8 + slot
   localparam logic [2:0] GPC_SLOT_DIR = 3'h0;
   localparam logic [2:0] GPC_SLOT_LEVEL = 3'h1;
   localparam logic [2:0] GPC_SLOT_LATCH = 3'h2;
   localparam logic [2:0] GPC_SLOT_ANALOG = 3'h3;
   localparam int GPC_PORT_SHIFT = 3;

   // change interrupt and interrupt registers
   localparam logic [7:0] GPC_ADDR_RISE = 8'h40;
   localparam logic [7:0] GPC_ADDR_FALL = 8'h41;
   localparam logic [7:0] GPC_ADDR_FLAG = 8'h42;
   localparam logic [7:0] GPC_ADDR_CTRL = 8'h43;
   localparam logic [7:0] GPC_ADDR_STAT = 8'h44;
   localparam logic [7:0] GPC_ADDR_MASK = 8'h45;

   // interrupt_control_reg fields
   localparam int GPC_CTRL_MEN_BIT = 0;
   localparam int GPC_CTRL_CFLAG_BIT = 1;

   // status and mask fields
   localparam int GPC_STAT_CHG_BIT = 0;

   // reset values
   localparam logic [7:0] GPC_RST_DIR = 8'hff;
   localparam logic [7:0] GPC_RST_LATCH = 8'h00;
   localparam logic [7:0] GPC_RST_ANALOG = 8'h00;
   localparam logic [7:0] GPC_RST_EDGE_EN = 8'h00;
   localparam logic [7:0] GPC_RST_FLAG = 8'h00;

   // index of the port that carries the change detectors
   localparam int GPC_CHG_PORT = 1;

   // ce cycles after reset before edges count: two sync stages plus one history
   localparam logic [1:0] GPC_PRIME_CYCLES = 2'h3;

endpackage

/* File: rtl/gpc_port_top.sv */
// gpc_port_top: general purpose ports with direction, latch, readback, analog
// select and a change interrupt on the second_port.
// assumes pins come from outside the clock domain; the register master follows
// the one-cycle strobe protocol and never strobes read and write together.
`timescale 1ns/10ps
module gpc_port_top
   import gpc_pkg::*;
#(
   parameter int NUM_PORTS = 5,
   parameter int PORT_W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [GPC_ADDR_W-1:0] addr,
   input wire logic [GPC_DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [GPC_DATA_W-1:0] rdata,
   input wire logic [NUM_PORTS*PORT_W-1:0] pin_in,
   output logic [NUM_PORTS*PORT_W-1:0] pin_out,
   output logic [NUM_PORTS*PORT_W-1:0] pin_oe,
   input wire logic [NUM_PORTS*PORT_W-1:0] periph_en,
   input wire logic [NUM_PORTS*PORT_W-1:0] periph_out,
   input wire logic [NUM_PORTS*PORT_W-1:0] periph_oe,
   output logic irq,
   output logic wake
);

   localparam int TOT_W = NUM_PORTS * PORT_W;
   localparam int CHG_LSB = GPC_CHG_PORT * PORT_W;

   // per-port register storage, indexed by port number
   logic [PORT_W-1:0] dir_q [NUM_PORTS];
   logic [PORT_W-1:0] latch_q [NUM_PORTS];
   logic [PORT_W-1:0] analog_q [NUM_PORTS];

   // change interrupt configuration
   logic [PORT_W-1:0] rise_en_q;
   logic [PORT_W-1:0] fall_en_q;
   logic master_en_q;

   // interrupt status and mask
   logic stat_q;
   logic mask_q;

   // pin synchronisers
   logic [TOT_W-1:0] sync1_q;
   logic [TOT_W-1:0] sync2_q;
   logic [TOT_W-1:0] level_in;

   // read path
   logic [GPC_DATA_W-1:0] rdata_q;
   logic [GPC_DATA_W-1:0] rdata_d;

   // change detector hookup
   logic combined_flag;
   logic any_det;

   // write enables, ce-gated so a frozen block ignores strobes
   logic reg_wr;
   logic [NUM_PORTS-1:0] dir_we;
   logic [NUM_PORTS-1:0] latch_we;
   logic [NUM_PORTS-1:0] analog_we;
   logic rise_we;
   logic fall_we;
   logic ctrl_we;
   logic flag_we;
   logic stat_we;
   logic stat_clr;
   logic mask_we;

   gpc_chg_if #(.W(PORT_W)) chg ();

   // true when the address hits a port slot of an existing port
   function automatic logic port_hit(
      input logic [GPC_ADDR_W-1:0] a,
      input logic [2:0] slot,
      input int p
   );
      logic [GPC_ADDR_W-GPC_PORT_SHIFT-1:0] idx;
      idx = a[GPC_ADDR_W-1:GPC_PORT_SHIFT];
      return (int'(idx) == p) && (a[GPC_PORT_SHIFT-1:0] == slot);
   endfunction

   // port number carried by an address
   function automatic int port_of(input logic [GPC_ADDR_W-1:0] a);
      return int'(a[GPC_ADDR_W-1:GPC_PORT_SHIFT]);
   endfunction

   // true when the address hits one single register
   function automatic logic reg_hit(
      input logic [GPC_ADDR_W-1:0] a,
      input logic [GPC_ADDR_W-1:0] target
   );
      return a == target;
   endfunction

   // a write strobe that counts in this cycle
   assign reg_wr = ce && wr;

   // [R3] per-port write enables; level and latch slots share the latch enable
   always_comb begin
      dir_we = '0;
      latch_we = '0;
      analog_we = '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
         dir_we[p] = reg_wr && port_hit(addr, GPC_SLOT_DIR, p);
         latch_we[p] = reg_wr && (port_hit(addr, GPC_SLOT_LEVEL, p)
            || port_hit(addr, GPC_SLOT_LATCH, p));
         analog_we[p] = reg_wr && port_hit(addr, GPC_SLOT_ANALOG, p);
      end
   end

   // write enables of the single registers
   always_comb begin
      rise_we = reg_wr && reg_hit(addr, GPC_ADDR_RISE);
      fall_we = reg_wr && reg_hit(addr, GPC_ADDR_FALL);
      ctrl_we = reg_wr && reg_hit(addr, GPC_ADDR_CTRL);
      flag_we = reg_wr && reg_hit(addr, GPC_ADDR_FLAG);
      stat_we = reg_wr && reg_hit(addr, GPC_ADDR_STAT);
      stat_clr = stat_we && wdata[GPC_STAT_CHG_BIT];
      mask_we = reg_wr && reg_hit(addr, GPC_ADDR_MASK);
   end

   // [R16] two-stage pin synchroniser
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else if (ce) begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   // [R5] analog pins blank the digital input
   always_comb begin
      level_in = '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
         level_in[p*PORT_W +: PORT_W] = sync2_q[p*PORT_W +: PORT_W] & ~analog_q[p];
      end
   end

   // [R2] direction registers per port
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            dir_q[p] <= GPC_RST_DIR[PORT_W-1:0];
         end
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (dir_we[p]) begin
               dir_q[p] <= wdata[PORT_W-1:0];
            end
         end
      end
   end

   // [R3] level and latch writes both load the output latch
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            latch_q[p] <= GPC_RST_LATCH[PORT_W-1:0];
         end
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (latch_we[p]) begin
               latch_q[p] <= wdata[PORT_W-1:0];
            end
         end
      end
   end

   // analog select registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            analog_q[p] <= GPC_RST_ANALOG[PORT_W-1:0];
         end
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (analog_we[p]) begin
               analog_q[p] <= wdata[PORT_W-1:0];
            end
         end
      end
   end

   // pin drivers
   always_comb begin
      pin_out = '0;
      pin_oe = '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int b = 0; b < PORT_W; b++) begin
            if (periph_en[p*PORT_W + b]) begin
               // [R1] peripheral owns the pin
               pin_out[p*PORT_W + b] = periph_out[p*PORT_W + b];
               pin_oe[p*PORT_W + b] = periph_oe[p*PORT_W + b];
            end else begin
               // [R15] direction zero drives latch
               pin_out[p*PORT_W + b] = latch_q[p][b];
               pin_oe[p*PORT_W + b] = ~dir_q[p][b];
            end
         end
      end
   end

   // [R8] [R9] edge enable registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rise_en_q <= GPC_RST_EDGE_EN[PORT_W-1:0];
         fall_en_q <= GPC_RST_EDGE_EN[PORT_W-1:0];
      end else begin
         if (rise_we) begin
            rise_en_q <= wdata[PORT_W-1:0];
         end
         if (fall_we) begin
            fall_en_q <= wdata[PORT_W-1:0];
         end
      end
   end

   // master change interrupt enable
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         master_en_q <= 1'b0;
      end else if (ctrl_we) begin
         master_en_q <= wdata[GPC_CTRL_MEN_BIT];
      end
   end

   // change detector on the second_port
   assign chg.level = level_in[CHG_LSB +: PORT_W];
   assign chg.rise_en = rise_en_q;
   assign chg.fall_en = fall_en_q;
   assign chg.flag_wr = flag_we;
   assign chg.flag_wdata = wdata[PORT_W-1:0];

   gpc_chg_det #(
      .W(PORT_W)
   ) u_det (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .io(chg)
   );

   // [R12] combined flag follows the pin flags
   assign combined_flag = |chg.flag;
   assign any_det = |chg.det;

   // sticky change event, write one clears, a new edge wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_q <= 1'b0;
      end else if (ce) begin
         if (any_det) begin
            stat_q <= 1'b1;
         end else if (stat_clr) begin
            stat_q <= 1'b0;
         end
      end
   end

   // interrupt mask
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask_q <= 1'b0;
      end else if (mask_we) begin
         mask_q <= wdata[GPC_STAT_CHG_BIT];
      end
   end

   // [R7] [R11] interrupt only with master enable
   assign irq = master_en_q & stat_q & mask_q;

   // [R14] wake request from pending change flags
   assign wake = master_en_q & combined_flag;

   // [R4] read decode: latch versus sampled pins
   always_comb begin
      rdata_d = '0;
      if (port_of(addr) < NUM_PORTS) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (port_hit(addr, GPC_SLOT_DIR, p)) begin
               rdata_d[PORT_W-1:0] = dir_q[p];
            end
            if (port_hit(addr, GPC_SLOT_LEVEL, p)) begin
               rdata_d[PORT_W-1:0] = level_in[p*PORT_W +: PORT_W];
            end
            if (port_hit(addr, GPC_SLOT_LATCH, p)) begin
               rdata_d[PORT_W-1:0] = latch_q[p];
            end
            if (port_hit(addr, GPC_SLOT_ANALOG, p)) begin
               rdata_d[PORT_W-1:0] = analog_q[p];
            end
         end
      end else begin
         case (addr)
            GPC_ADDR_RISE: begin
               rdata_d[PORT_W-1:0] = rise_en_q;
            end
            GPC_ADDR_FALL: begin
               rdata_d[PORT_W-1:0] = fall_en_q;
            end
            GPC_ADDR_FLAG: begin
               rdata_d[PORT_W-1:0] = chg.flag;
            end
            GPC_ADDR_CTRL: begin
               rdata_d[GPC_CTRL_MEN_BIT] = master_en_q;
               rdata_d[GPC_CTRL_CFLAG_BIT] = combined_flag;
            end
            GPC_ADDR_STAT: begin
               rdata_d[GPC_STAT_CHG_BIT] = stat_q;
            end
            GPC_ADDR_MASK: begin
               rdata_d[GPC_STAT_CHG_BIT] = mask_q;
            end
            default: begin
               rdata_d = '0;
            end
         endcase
      end
   end

   // read data captured on the strobe, shown only in the next cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (ce) begin
         if (rd) begin
            rdata_q <= rdata_d;
         end else begin
            rdata_q <= '0;
         end
      end
   end

   assign rdata = rdata_q;

endmodule

/* File: sim/gpc_pin_model.sv */
// gpc_pin_model: outside circuitry on the port pins.
// assumes every pin the block leaves free is driven from outside at ext_lvl.
`timescale 1ns/10ps
module gpc_pin_model #(
   parameter int W = 40
) (
   input wire logic [W-1:0] pin_out,
   input wire logic [W-1:0] pin_oe,
   input wire logic [W-1:0] ext_lvl,
   output logic [W-1:0] pin_lvl
);
   // wire level: the block's driver wins where enabled
   assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

/* File: sim/gpc_port_asserts.sv */
// gpc_port_asserts: port-level checks for the port block.
// assumes binding to gpc_port_top and one clock; ce may drop for a few cycles.
`timescale 1ns/10ps
module gpc_port_asserts
   import gpc_pkg::*;
#(
   parameter int NUM_PORTS = 5,
   parameter int PORT_W = 8,
   parameter int NW = NUM_PORTS * PORT_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [GPC_ADDR_W-1:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [GPC_DATA_W-1:0] rdata,
   input wire logic [NW-1:0] pin_out,
   input wire logic [NW-1:0] pin_oe,
   input wire logic [NW-1:0] periph_en,
   input wire logic [NW-1:0] periph_out,
   input wire logic [NW-1:0] periph_oe,
   input wire logic irq,
   input wire logic wake
);
   // all checks on the one clock, idle in reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // pins owned by a peripheral take its drive
   a_periph_oe_pass: assert property (((pin_oe ^ periph_oe) & periph_en) == '0)
      else $error("peripheral enable not passed to pin");
   a_periph_out_pass: assert property (((pin_out ^ periph_out) & periph_en) == '0)
      else $error("peripheral value not passed to pin");
   // read data stands only in the cycle after a read
   a_rdata_quiet: assert property ($past(ce) && !$past(rd) |-> rdata == '0)
      else $error("read data outside its cycle");
   a_unmapped_zero: assert property ($past(ce && rd && addr == 8'h7f) |-> rdata == '0)
      else $error("unmapped read not zero");
   // gpio drivers switch on and values move only on a register write
   a_oe_on_write: assert property (!$past(wr) && $stable(periph_en)
      |-> (pin_oe & ~periph_en & ~$past(pin_oe)) == '0) else $error("driver on without write");
   a_out_on_write: assert property (!$past(wr) && $stable(periph_en)
      && $stable(periph_out) |-> $stable(pin_out)) else $error("pin value moved without write");
   // an interrupt from a pin event comes with a set flag
   a_irq_cause: assert property ($rose(irq) && !$past(wr) |-> wake)
      else $error("interrupt without flag");
   // interrupt and wake fall only when software writes
   a_irq_fall: assert property ($fell(irq) |-> $past(wr))
      else $error("interrupt dropped without write");
   a_wake_fall: assert property ($fell(wake) |-> $past(wr))
      else $error("flag lost without write");

   // main scenarios reached
   c_irq: cover property ($rose(irq));
   c_wake_only: cover property (wake && !irq);
   c_periph: cover property ((periph_en & pin_oe) != '0);
endmodule

bind gpc_port_top gpc_port_asserts #(.NUM_PORTS(NUM_PORTS), .PORT_W(PORT_W)) u_chk (
   .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
   .pin_out(pin_out), .pin_oe(pin_oe), .periph_en(periph_en), .periph_out(periph_out),
   .periph_oe(periph_oe), .irq(irq), .wake(wake)
);

/* File: sim/gpc_port_tb_top.sv */
// gpc_port_tb_top: self-checking bench for the port block.
// assumes the pin model closes the pins; ce drops once to show strobes are ignored.
`timescale 1ns/10ps
module gpc_port_tb_top
   import gpc_pkg::*;
;
   localparam int NB = 40;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, rd_p = 1'b0;
   logic [7:0] addr = '0, wdata = '0, rdata;
   logic [NB-1:0] pin_in, pin_out, pin_oe, ext = '0, pen = '0, pout = '0, poe = '0;
   logic irq, wake;
   int bad_count = 0, compares = 0;
   logic [7:0] exp_q[$];
   string nm_q[$];

   always #50 clk = ~clk;

   gpc_port_top u_dut (
      .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_en(pen),
      .periph_out(pout), .periph_oe(poe), .irq(irq), .wake(wake)
   );
   gpc_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext), .pin_lvl(pin_in));

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input string nm, input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      nm_q.push_back(nm);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // read results are matched against the oldest note
   always @(posedge clk) rd_p <= rd;
   always @(negedge clk) begin
      if (rd_p) begin
         check(nm_q.pop_front(), rdata, exp_q.pop_front());
      end
   end

   // hang guard far beyond the few hundred cycles of the sequence
   initial begin
      #400000;
      bad_count++;
      finish_test();
   end

   initial begin
      logic [7:0] v, e;
      void'($urandom(21));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // direction reset value, latch and readback on every port
      for (int p = 0; p < 5; p++) begin
         v = 8'($urandom);
         e = 8'($urandom);
         ext[p*8 +: 8] <= e;
         rreg("dir reset", 8'(p * 8), GPC_RST_DIR);
         wreg(8'(p * 8 + 1), v);
         rreg("latch", 8'(p * 8 + 2), v);
         wreg(8'(p * 8), 8'h00);
         repeat (3) @(posedge clk);
         rreg("driven pins", 8'(p * 8 + 1), v);
         @(negedge clk);
         check("pin_out", pin_out[p*8 +: 8], v);
         check("pin_oe", pin_oe[p*8 +: 8], 8'hff);
         wreg(8'(p * 8), 8'hff);
         wreg(8'(p * 8 + 2), ~v);
         repeat (3) @(posedge clk);
         rreg("input pins", 8'(p * 8 + 1), e);
         rreg("latch write", 8'(p * 8 + 2), ~v);
      end
      wreg(8'h7f, 8'h5a);
      rreg("unmapped", 8'h7f, 8'h00);
      rreg("absent port", 8'h28, 8'h00);
      $display("test registers done");
      // analog select blanks the digital path
      ext[7:0] <= 8'hff;
      wreg(8'h03, 8'h0f);
      repeat (3) @(posedge clk);
      rreg("analog", 8'h01, 8'hf0);
      // peripheral owns port 2
      v = 8'($urandom);
      e = 8'($urandom);
      pen[23:16] <= 8'hff;
      pout[23:16] <= v;
      poe[23:16] <= e;
      wreg(8'h10, 8'h00);
      @(negedge clk);
      check("periph oe", pin_oe[23:16], e);
      repeat (3) @(posedge clk);
      rreg("periph read", 8'h11, (e & v) | (~e & ext[23:16]));
      pen <= '0;
      $display("test pins done");
      // change detection on port 1
      ext[15:8] <= 8'h00;
      repeat (4) @(posedge clk);
      wreg(GPC_ADDR_RISE, 8'h01);
      wreg(GPC_ADDR_FALL, 8'h02);
      wreg(GPC_ADDR_MASK, 8'h01);
      wreg(GPC_ADDR_CTRL, 8'h01);
      @(posedge clk) ext[15:8] <= 8'h07;
      repeat (5) @(posedge clk);
      rreg("rise flags", GPC_ADDR_FLAG, 8'h01);
      rreg("combined", GPC_ADDR_CTRL, 8'h03);
      check("irq wake", {6'h0, irq, wake}, 8'h03);
      @(posedge clk) ext[15:8] <= 8'h00;
      repeat (5) @(posedge clk);
      rreg("fall flags", GPC_ADDR_FLAG, 8'h03);
      wreg(GPC_ADDR_FLAG, 8'h00);
      rreg("flags cleared", GPC_ADDR_FLAG, 8'h00);
      rreg("combined clear", GPC_ADDR_CTRL, 8'h01);
      wreg(GPC_ADDR_STAT, 8'h01);
      @(negedge clk);
      check("irq cleared", {6'h0, irq, wake}, 8'h00);
      // both edges with the master enable off
      wreg(GPC_ADDR_CTRL, 8'h00);
      wreg(GPC_ADDR_RISE, 8'h04);
      wreg(GPC_ADDR_FALL, 8'h04);
      @(posedge clk) ext[15:8] <= 8'h04;
      repeat (5) @(posedge clk);
      rreg("both rise", GPC_ADDR_FLAG, 8'h04);
      wreg(GPC_ADDR_FLAG, 8'h00);
      @(posedge clk) ext[15:8] <= 8'h00;
      repeat (5) @(posedge clk);
      rreg("both fall", GPC_ADDR_FLAG, 8'h04);
      rreg("status", GPC_ADDR_STAT, 8'h01);
      check("master off", {6'h0, irq, wake}, 8'h00);
      // masked interrupt still wakes
      wreg(GPC_ADDR_MASK, 8'h00);
      wreg(GPC_ADDR_CTRL, 8'h01);
      @(negedge clk);
      check("masked wake", {6'h0, irq, wake}, 8'h01);
      // an edge in the very cycle of a clearing write keeps its flag
      wreg(GPC_ADDR_FLAG, 8'h00);
      rreg("flag clear", GPC_ADDR_FLAG, 8'h00);
      @(posedge clk) ext[15:8] <= 8'h04;
      @(posedge clk);
      wreg(GPC_ADDR_FLAG, 8'h00);
      rreg("edge beats clear", GPC_ADDR_FLAG, 8'h04);
      // a write while ce is low is ignored
      ce <= 1'b0;
      wreg(GPC_ADDR_RISE, 8'hff);
      ce <= 1'b1;
      rreg("ce frozen", GPC_ADDR_RISE, 8'h04);
      $display("test change done");
      repeat (2) @(posedge clk);
      finish_test();
   end
endmodule
